/* rtl/chan_filter_pkg.sv */
/*
 * constants and carrier types for the channel ram filter and gain control block.
 * assumes one core clock and a single-cycle register write/read port.
 */
package chan_filter_pkg;
	// ------------------------------------------------------------
	// widths and sizes
	// ------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int REG_W = 20;
	localparam int ADDR_W = 7;
	localparam int ACC_W = 48;
	localparam int MEM_DEPTH = 64;
	localparam int HIST_DEPTH = 128;
	localparam int DCOEF_FRAC = 13;
	localparam int CCOEF_FRAC = 19;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_D_CTL = 7'h00;
	localparam logic [6:0] IDX_D_PTR = 7'h01;
	localparam logic [6:0] IDX_D_TAPS = 7'h02;
	localparam logic [6:0] IDX_D_START = 7'h03;
	localparam logic [6:0] IDX_D_FINAL = 7'h04;
	localparam logic [6:0] IDX_D_COEF = 7'h05;
	localparam logic [6:0] IDX_C_CTL = 7'h06;
	localparam logic [6:0] IDX_C_PTR = 7'h07;
	localparam logic [6:0] IDX_C_TAPS = 7'h08;
	localparam logic [6:0] IDX_G_CTL = 7'h09;
	localparam logic [6:0] IDX_G_HOLD = 7'h0a;
	localparam logic [6:0] IDX_STATUS = 7'h0b;
	localparam logic [6:0] IDX_C_MEM = 7'h40;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int F_BYPASS = 11;
	localparam int F_SYM = 10;
	localparam int F_SCALE = 8;
	localparam int F_RATE = 4;
	localparam int F_PHASE = 0;
	localparam int G_CHSEL = 10;
	localparam int G_PIN = 8;
	localparam int G_LEN = 5;
	localparam int G_MODE = 4;
	localparam int G_NOW = 3;
	localparam int G_INIT = 2;
	localparam int G_FIRST = 1;
	localparam int G_BYP = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [11:0] RST_FCTL = 12'h800;
	localparam logic [10:0] RST_GCTL = 11'h000;
	localparam logic [15:0] RST_HOLD = 16'h0001;
	// ------------------------------------------------------------
	// carriers and state
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} sample_t;
	typedef struct packed {
		logic busy;
		logic [3:0] cnt;
		logic [6:0] idx;
		logic [5:0] ptr;
		logic [47:0] acc;
		logic out_vld;
		logic [15:0] out;
	} filt_t;
	typedef struct packed {
		logic [1:0][11:0] ctl;
		logic [1:0][7:0] ptr;
		logic [1:0][6:0] taps;
		logic [5:0] ld_start;
		logic [5:0] ld_end;
		logic [5:0] ld_ptr;
		logic [63:0][13:0] dmem;
		logic [63:0][19:0] cmem;
		logic [1:0][127:0][15:0] hist;
		filt_t [1:0] filt;
		logic [10:0] gctl;
		logic [15:0] hold;
		logic [15:0] hcnt;
		logic hrun;
		logic synced;
		logic gsync;
		logic ginit;
		sample_t out;
		logic [19:0] rdata;
	} state_t;
endpackage

/* rtl/chan_filter.sv */
/*
 * decimating and channel ram coefficient filters with gain loop sync and
 * word-length control. registers are written and read over a simple indexed
 * port. assumes input samples and sync pins are synchronous to mclk_i.
 */
// Overview of operation
// - decimating filter bypass passes input unchanged, else filters as configured
// - symmetry bit: half response loaded, mirrored to reach 128 taps
// - decimating scale code 00..11 shifts down 3,2,1,0 bits
// - decimating filter decimates by rate field plus one, filtering even at one
// - decimating phase picks which input of each group starts a computation
// - decimating coefficient offset is shadowed, taken at next computation start
// - decimating filter computes tap field plus one taps
// - decimating memory 64x14, loaded between start and final addresses
// - channel filter bypass passes input unchanged, else filters as programmed
// - channel filter symmetry bit mirrors half response up to 128 taps
// - channel scale code 00..11 shifts down 3,2,1,0 bits
// - channel filter decimates by rate plus one with phase alignment
// - channel coefficient offset is shadowed, taken at next computation start
// - channel filter computes tap field plus one taps
// - channel memory holds 64 words of 20-bit two's complement
// - gain sync from channel sync or one of four external sync inputs
// - output word width 16,12,10,8,7,6,5,4 by three-bit code
// - mode bit selects desired signal level or constant clipping level
// - software sync-now bit synchronises gain loop regardless of channel sync
// - sync with initialise bit reloads loop parameters; update emitted always
// - first-sync-only ignores all sync requests after the first
// - gain bypass skips loop, output still truncated to chosen width
// - sync loads hold-off counter; delivered at one; zero blocks sync
`timescale 1ns/1ps
module chan_filter (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [19:0] reg_wdata_i,
	output logic [19:0] reg_rdata_o,
	// sample stream
	input wire chan_filter_pkg::sample_t in_sample_i,
	output logic in_ready_o,
	output chan_filter_pkg::sample_t out_sample_o,
	// sync inputs
	input wire logic channel_sync_i,
	input wire logic [3:0] external_sync_input_i,
	// gain loop control
	output logic gain_sync_o,
	output logic gain_init_o,
	output logic gain_level_mode_o,
	output logic gain_loop_enable_o
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [5:0] coef_index(input logic [6:0] i, input logic [6:0] taps, input logic sym);
		logic [6:0] mir;
		mir = taps - i;
		if (sym && (i > mir)) begin
			return mir[5:0];
		end
		return i[5:0];
	endfunction

	function automatic logic [15:0] scale_out(input logic [47:0] acc, input int frac, input logic [1:0] code);
		logic signed [47:0] tmp;
		int sh;
		sh = frac + 3 - int'(code);
		tmp = $signed(acc) >>> sh;
		return tmp[15:0];
	endfunction

	function automatic logic [15:0] len_mask(input logic [2:0] code);
		case (code)
			3'h0: return 16'hffff;
			3'h1: return 16'hfff0;
			3'h2: return 16'hffc0;
			3'h3: return 16'hff00;
			3'h4: return 16'hfe00;
			3'h5: return 16'hfc00;
			3'h6: return 16'hf800;
			default: return 16'hf000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	chan_filter_pkg::state_t s_reg;
	chan_filter_pkg::state_t s_next;
	logic [1:0] in_ok;
	logic [1:0] take;
	logic [15:0] src [2];
	logic trig;
	logic sync_pin;

	assign in_ok[0] = !s_reg.filt[0].busy && !s_reg.filt[0].out_vld;
	assign in_ok[1] = !s_reg.filt[1].busy && !s_reg.filt[1].out_vld;
	assign take[0] = in_sample_i.valid && in_ok[0];
	assign take[1] = s_reg.filt[0].out_vld && in_ok[1];
	assign src[0] = in_sample_i.data;
	assign src[1] = s_reg.filt[0].out;
	assign in_ready_o = in_ok[0];

	// sync source select and software sync-now
	always_comb begin
		if (s_reg.gctl[chan_filter_pkg::G_CHSEL]) begin
			sync_pin = channel_sync_i;
		end else begin
			sync_pin = external_sync_input_i[s_reg.gctl[chan_filter_pkg::G_PIN +: 2]];
		end
		trig = sync_pin || (reg_wr_i && reg_addr_i == chan_filter_pkg::IDX_G_CTL &&
			reg_wdata_i[chan_filter_pkg::G_NOW]);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [11:0] c;
		logic [5:0] k;
		logic [19:0] cf;
		logic signed [35:0] prod;
		logic [47:0] acc_n;
		c = '0;
		k = '0;
		cf = '0;
		prod = '0;
		acc_n = '0;
		s_next = s_reg;
		s_next.gsync = 1'b0;
		s_next.ginit = 1'b0;
		s_next.out.valid = 1'b0;

		// register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				chan_filter_pkg::IDX_D_CTL: s_next.ctl[0] = reg_wdata_i[11:0];
				chan_filter_pkg::IDX_D_PTR: s_next.ptr[0] = reg_wdata_i[7:0];
				chan_filter_pkg::IDX_D_TAPS: s_next.taps[0] = reg_wdata_i[6:0];
				chan_filter_pkg::IDX_D_START: begin
					s_next.ld_start = reg_wdata_i[5:0];
					s_next.ld_ptr = reg_wdata_i[5:0];
				end
				chan_filter_pkg::IDX_D_FINAL: s_next.ld_end = reg_wdata_i[5:0];
				chan_filter_pkg::IDX_D_COEF: begin
					s_next.dmem[s_reg.ld_ptr] = reg_wdata_i[13:0];
					s_next.ld_ptr = (s_reg.ld_ptr == s_reg.ld_end) ? s_reg.ld_start : s_reg.ld_ptr + 6'h01;
				end
				chan_filter_pkg::IDX_C_CTL: s_next.ctl[1] = reg_wdata_i[11:0];
				chan_filter_pkg::IDX_C_PTR: s_next.ptr[1] = {2'h0, reg_wdata_i[5:0]};
				chan_filter_pkg::IDX_C_TAPS: s_next.taps[1] = reg_wdata_i[6:0];
				chan_filter_pkg::IDX_G_CTL: s_next.gctl = reg_wdata_i[10:0] & 11'h7f7;
				chan_filter_pkg::IDX_G_HOLD: s_next.hold = reg_wdata_i[15:0];
				default: begin
					if (reg_addr_i[6]) begin
						s_next.cmem[reg_addr_i[5:0]] = reg_wdata_i;
					end
				end
			endcase
		end

		// register reads
		if (reg_rd_i) begin
			case (reg_addr_i)
				chan_filter_pkg::IDX_D_CTL: s_next.rdata = {8'h00, s_reg.ctl[0]};
				chan_filter_pkg::IDX_D_PTR: s_next.rdata = {12'h000, s_reg.ptr[0]};
				chan_filter_pkg::IDX_D_TAPS: s_next.rdata = {13'h0000, s_reg.taps[0]};
				chan_filter_pkg::IDX_D_START: s_next.rdata = {14'h0000, s_reg.ld_start};
				chan_filter_pkg::IDX_D_FINAL: s_next.rdata = {14'h0000, s_reg.ld_end};
				chan_filter_pkg::IDX_D_COEF: s_next.rdata = {6'h00, s_reg.dmem[s_reg.ld_ptr]};
				chan_filter_pkg::IDX_C_CTL: s_next.rdata = {8'h00, s_reg.ctl[1]};
				chan_filter_pkg::IDX_C_PTR: s_next.rdata = {12'h000, s_reg.ptr[1]};
				chan_filter_pkg::IDX_C_TAPS: s_next.rdata = {13'h0000, s_reg.taps[1]};
				chan_filter_pkg::IDX_G_CTL: s_next.rdata = {9'h000, s_reg.gctl};
				chan_filter_pkg::IDX_G_HOLD: s_next.rdata = {4'h0, s_reg.hold};
				chan_filter_pkg::IDX_STATUS: s_next.rdata = {16'h0000, s_reg.hrun, s_reg.synced,
					s_reg.filt[1].busy, s_reg.filt[0].busy};
				default: s_next.rdata = reg_addr_i[6] ? s_reg.cmem[reg_addr_i[5:0]] : 20'h00000;
			endcase
		end

		// both ram filters share one sequencer shape
		for (int f = 0; f < 2; f++) begin
			c = s_reg.ctl[f];
			if (f == 0) begin
				s_next.filt[0].out_vld = s_reg.filt[0].out_vld && !in_ok[1];
			end else begin
				s_next.filt[1].out_vld = 1'b0;
			end
			if (take[f]) begin
				if (c[chan_filter_pkg::F_BYPASS]) begin
					s_next.filt[f].out = src[f];
					s_next.filt[f].out_vld = 1'b1;
				end else begin
					s_next.hist[f] = {s_reg.hist[f][126:0], src[f]};
					s_next.filt[f].cnt = (s_reg.filt[f].cnt == c[chan_filter_pkg::F_RATE +: 4]) ? 4'h0 :
						s_reg.filt[f].cnt + 4'h1;
					if (s_reg.filt[f].cnt == c[chan_filter_pkg::F_PHASE +: 4]) begin
						s_next.filt[f].busy = 1'b1;
						s_next.filt[f].idx = 7'h00;
						s_next.filt[f].ptr = s_reg.ptr[f][5:0];
						s_next.filt[f].acc = '0;
					end
				end
			end
			if (s_reg.filt[f].busy) begin
				k = s_reg.filt[f].ptr + coef_index(s_reg.filt[f].idx, s_reg.taps[f],
					c[chan_filter_pkg::F_SYM]);
				cf = (f == 0) ? {{6{s_reg.dmem[k][13]}}, s_reg.dmem[k]} : s_reg.cmem[k];
				prod = $signed(cf) * $signed(s_reg.hist[f][s_reg.filt[f].idx]);
				acc_n = s_reg.filt[f].acc + {{12{prod[35]}}, prod};
				s_next.filt[f].acc = acc_n;
				s_next.filt[f].idx = s_reg.filt[f].idx + 7'h01;
				if (s_reg.filt[f].idx == s_reg.taps[f]) begin
					s_next.filt[f].busy = 1'b0;
					s_next.filt[f].out_vld = 1'b1;
					s_next.filt[f].out = scale_out(acc_n, (f == 0) ? chan_filter_pkg::DCOEF_FRAC :
						chan_filter_pkg::CCOEF_FRAC, c[chan_filter_pkg::F_SCALE +: 2]);
				end
			end
		end

		// output word, truncated whether or not the loop is bypassed
		if (s_reg.filt[1].out_vld) begin
			s_next.out.valid = 1'b1;
			s_next.out.data = s_reg.filt[1].out & len_mask(s_reg.gctl[chan_filter_pkg::G_LEN +: 3]);
		end

		// sync hold-off
		if (s_reg.hrun) begin
			s_next.hcnt = s_reg.hcnt - 16'h0001;
			if (s_reg.hcnt == 16'h0002) begin
				s_next.hrun = 1'b0;
				s_next.gsync = 1'b1;
				s_next.ginit = s_reg.gctl[chan_filter_pkg::G_INIT];
				s_next.synced = 1'b1;
			end
		end
		if (trig && !(s_reg.gctl[chan_filter_pkg::G_FIRST] && (s_reg.synced || s_reg.hrun))) begin
			if (s_reg.hold == 16'h0001) begin
				s_next.hrun = 1'b0;
				s_next.gsync = 1'b1;
				s_next.ginit = s_reg.gctl[chan_filter_pkg::G_INIT];
				s_next.synced = 1'b1;
			end else if (s_reg.hold != 16'h0000) begin
				s_next.hrun = 1'b1;
				s_next.hcnt = s_reg.hold;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.ctl[0] <= chan_filter_pkg::RST_FCTL;
			s_reg.ctl[1] <= chan_filter_pkg::RST_FCTL;
			s_reg.gctl <= chan_filter_pkg::RST_GCTL;
			s_reg.hold <= chan_filter_pkg::RST_HOLD;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_o = s_reg.rdata;
	assign out_sample_o = s_reg.out;
	assign gain_sync_o = s_reg.gsync;
	assign gain_init_o = s_reg.ginit;
	assign gain_level_mode_o = s_reg.gctl[chan_filter_pkg::G_MODE];
	assign gain_loop_enable_o = !s_reg.gctl[chan_filter_pkg::G_BYP];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_hold3_load;
		trig && s_reg.hold == 16'h0003 && !s_reg.hrun && !s_reg.gctl[chan_filter_pkg::G_FIRST];
	endsequence
	sequence seq_hold3_fire;
		!gain_sync_o ##1 !gain_sync_o ##1 gain_sync_o;
	endsequence

	a_decimating_ram_filter_bypass_pass: assert property (
		take[0] && s_reg.ctl[0][chan_filter_pkg::F_BYPASS] |=>
			s_reg.filt[0].out_vld && s_reg.filt[0].out == $past(in_sample_i.data))
		else $error("decimating bypass did not pass input");
	a_channel_ram_filter_bypass_pass: assert property (
		take[1] && s_reg.ctl[1][chan_filter_pkg::F_BYPASS] |=>
			s_reg.filt[1].out_vld && s_reg.filt[1].out == $past(s_reg.filt[0].out))
		else $error("channel bypass did not pass input");
	a_decimating_ram_filter_tap_end: assert property (
		s_reg.filt[0].busy && s_reg.filt[0].idx == s_reg.taps[0] |=> !s_reg.filt[0].busy && s_reg.filt[0].out_vld)
		else $error("decimating filter tap count wrong");
	a_channel_ram_filter_tap_end: assert property (
		s_reg.filt[1].busy && s_reg.filt[1].idx != s_reg.taps[1] |=> s_reg.filt[1].busy)
		else $error("channel filter stopped early");
	a_decimating_ram_filter_ptr_shadow: assert property (
		s_reg.filt[0].busy && s_reg.filt[0].idx != 7'h00 |-> s_reg.filt[0].ptr == $past(s_reg.filt[0].ptr))
		else $error("decimating pointer changed mid computation");
	a_channel_ram_filter_ptr_take: assert property (
		$rose(s_reg.filt[1].busy) |-> s_reg.filt[1].ptr == $past(s_reg.ptr[1][5:0]))
		else $error("channel pointer not taken at start");
	a_decim_cnt_range: assert property (
		s_reg.filt[0].cnt <= s_reg.ctl[0][chan_filter_pkg::F_RATE +: 4] || $past(reg_wr_i))
		else $error("decimation count beyond rate");
	a_hold_zero_block: assert property (
		trig && s_reg.hold == 16'h0000 && !s_reg.hrun |=> !gain_sync_o)
		else $error("sync delivered with zero hold-off");
	a_hold_three_delay: assert property (
		seq_hold3_load |=> seq_hold3_fire)
		else $error("hold-off of three mistimed");
	a_first_only: assert property (
		s_reg.gctl[chan_filter_pkg::G_FIRST] && s_reg.synced && $past(s_reg.synced) |-> !gain_sync_o)
		else $error("repeat sync acted on in first-sync-only mode");
	a_init_with_sync: assert property (
		gain_init_o |-> gain_sync_o)
		else $error("initialise without sync");
	a_out_trunc: assert property (
		out_sample_o.valid |-> (out_sample_o.data & ~len_mask(s_reg.gctl[chan_filter_pkg::G_LEN +: 3])) == 16'h0000
			|| $past(reg_wr_i))
		else $error("output word not truncated");

	sequence seq_dec_start;
		take[0] && !s_reg.ctl[0][chan_filter_pkg::F_BYPASS] &&
			s_reg.filt[0].cnt == s_reg.ctl[0][chan_filter_pkg::F_PHASE +: 4];
	endsequence
	sequence seq_chan_start;
		take[1] && !s_reg.ctl[1][chan_filter_pkg::F_BYPASS] &&
			s_reg.filt[1].cnt == s_reg.ctl[1][chan_filter_pkg::F_PHASE +: 4];
	endsequence
	sequence seq_dec_run_first;
		s_reg.filt[0].busy && s_reg.filt[0].idx == 7'h00;
	endsequence
	sequence seq_chan_run_first;
		s_reg.filt[1].busy && s_reg.filt[1].idx == 7'h00;
	endsequence
	a_decimating_ram_filter_phase_start: assert property (
		seq_dec_start |=> seq_dec_run_first)
		else $error("decimating computation not started at phase");
	a_channel_ram_filter_phase_start: assert property (
		seq_chan_start |=> seq_chan_run_first)
		else $error("channel computation not started at phase");
	a_decimating_ram_filter_skip_phase: assert property (
		take[0] && !s_reg.ctl[0][chan_filter_pkg::F_BYPASS] &&
			s_reg.filt[0].cnt != s_reg.ctl[0][chan_filter_pkg::F_PHASE +: 4] |=> !s_reg.filt[0].busy)
		else $error("decimating computation started off phase");
	a_decimating_ram_filter_ptr_take: assert property (
		$rose(s_reg.filt[0].busy) |-> s_reg.filt[0].ptr == $past(s_reg.ptr[0][5:0]))
		else $error("decimating pointer not taken at start");
	a_channel_ram_filter_ptr_shadow: assert property (
		s_reg.filt[1].busy && s_reg.filt[1].idx != 7'h00 |-> s_reg.filt[1].ptr == $past(s_reg.filt[1].ptr))
		else $error("channel pointer changed mid computation");
	a_channel_ram_filter_cnt_range: assert property (
		s_reg.filt[1].cnt <= s_reg.ctl[1][chan_filter_pkg::F_RATE +: 4] || $past(reg_wr_i))
		else $error("channel decimation count beyond rate");
	a_hold_one_now: assert property (
		trig && s_reg.hold == 16'h0001 && !s_reg.gctl[chan_filter_pkg::G_FIRST] |=> gain_sync_o)
		else $error("hold-off of one not immediate");
	a_hold_count_down: assert property (
		s_reg.hrun && !trig |=> s_reg.hcnt == $past(s_reg.hcnt) - 16'h0001)
		else $error("hold-off counter did not count down");
	a_init_follows_bit: assert property (
		gain_sync_o |-> gain_init_o == $past(s_reg.gctl[chan_filter_pkg::G_INIT]))
		else $error("initialise pulse does not follow control bit");
	a_out_word_trunc: assert property (
		out_sample_o.valid |-> out_sample_o.data == ($past(s_reg.filt[1].out) &
			len_mask($past(s_reg.gctl[chan_filter_pkg::G_LEN +: 3]))))
		else $error("output word differs from truncated stage output");

endmodule

/* dv/stream_partner.sv */
/*
 * upstream sample source and downstream sink for the channel filter bench.
 * assumes a sample is taken on an edge where valid and ready are both high.
 */
`timescale 1ns/1ps
module stream_partner (
	// clock
	input wire logic mclk_i,
	// design side
	input wire logic in_ready_i,
	input wire chan_filter_pkg::sample_t out_sample_i,
	output chan_filter_pkg::sample_t in_sample_o
);
	// ------------------------------------------------
	// source and sink
	// ------------------------------------------------
	logic [15:0] got_q[$];
	initial in_sample_o = '0;
	task automatic send(input logic [15:0] d, input int gap);
		repeat (gap + 1) @(posedge mclk_i);
		#1;
		in_sample_o = {1'b1, d};
		while (in_ready_i !== 1'b1) begin
			@(posedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		#1;
		// released line shows the inverse, never a stale copy
		in_sample_o = {1'b0, ~d};
	endtask
	always @(posedge mclk_i) begin
		if (out_sample_i.valid === 1'b1) begin
			got_q.push_back(out_sample_i.data);
		end
	end
endmodule

/* dv/testbench.sv */
/*
 * self-checking bench: register table, stream paths, scaling, decimation,
 * taps and gain sync. assumes stream_partner as upstream and downstream.
 */
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------
	// wiring and tables
	// ------------------------------------------------
	typedef struct packed {
		logic [6:0] a;
		logic [19:0] d;
		logic [19:0] e;
	} row_t;
	logic mclk_i, rst_n_i, reg_wr_i, reg_rd_i, channel_sync_i, in_ready_o, ini;
	logic gain_sync_o, gain_init_o, gain_level_mode_o, gain_loop_enable_o;
	logic [6:0] reg_addr_i;
	logic [19:0] reg_wdata_i, reg_rdata_o, q;
	logic [15:0] q16;
	logic [10:0] g;
	logic [3:0] external_sync_input_i;
	chan_filter_pkg::sample_t in_sample_i, out_sample_o;
	int bad_count, compares, first, cnt;
	logic [15:0] msk[8] = '{16'hffff, 16'hfff0, 16'hffc0, 16'hff00, 16'hfe00, 16'hfc00, 16'hf800, 16'hf000};
	logic [6:0] ra[5] = '{7'h00, 7'h06, 7'h09, 7'h0a, 7'h01};
	logic [19:0] re[5] = '{20'h800, 20'h800, 20'h0, 20'h1, 20'h0};
	row_t rows[13] = '{'{7'h00, 20'hfff, 20'hfff}, '{7'h01, 20'h1ab, 20'h0ab}, '{7'h02, 20'h0ff, 20'h07f},
		'{7'h03, 20'h07f, 20'h03f}, '{7'h04, 20'h07f, 20'h03f}, '{7'h06, 20'habc, 20'habc},
		'{7'h07, 20'h0ff, 20'h03f}, '{7'h08, 20'h0ff, 20'h07f}, '{7'h09, 20'h7ff, 20'h7f7},
		'{7'h0a, 20'h1234, 20'h1234}, '{7'h40, 20'hfffff, 20'hfffff}, '{7'h7f, 20'h80001, 20'h80001},
		'{7'h0c, 20'h5, 20'h0}};
	chan_filter dut_u (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
		.in_sample_i, .in_ready_o, .out_sample_o, .channel_sync_i, .external_sync_input_i, .gain_sync_o,
		.gain_init_o, .gain_level_mode_o, .gain_loop_enable_o);
	stream_partner ptr_u (.mclk_i, .in_ready_i(in_ready_o), .out_sample_i(out_sample_o), .in_sample_o(in_sample_i));
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge mclk_i);
		#1;
		rst_n_i = 1'b0;
		repeat (12) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [19:0] d);
		@(posedge mclk_i);
		#1;
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge mclk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [19:0] r);
		@(posedge mclk_i);
		#1;
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(posedge mclk_i);
		#1;
		reg_rd_i = 1'b0;
		r = reg_rdata_o;
	endtask
	task automatic collect(input int k);
		int n;
		n = 0;
		while (ptr_u.got_q.size() < k && n < 400) begin
			@(posedge mclk_i);
			n++;
		end
		repeat (20) @(posedge mclk_i);
		#1;
	endtask
	task automatic xfer(input logic [15:0] d, output logic [15:0] r);
		ptr_u.got_q.delete();
		ptr_u.send(d, 0);
		collect(1);
		r = ptr_u.got_q[0];
	endtask
	// coefficient 0.5 at word 0 of both memories
	task automatic prep();
		do_reset();
		wr(7'h03, 20'h0);
		wr(7'h04, 20'h3f);
		wr(7'h05, 20'h1000);
		wr(7'h40, 20'h40000);
	endtask
	task automatic pulse(input logic [3:0] p, input logic c);
		@(posedge mclk_i);
		#1;
		external_sync_input_i = p;
		channel_sync_i = c;
		@(posedge mclk_i);
		#1;
		external_sync_input_i = 4'h0;
		channel_sync_i = 1'b0;
	endtask
	task automatic watch(output int f, output int c, output logic i);
		f = 0;
		c = 0;
		i = 1'b0;
		for (int n = 1; n <= 30; n++) begin
			if (gain_sync_o === 1'b1) begin
				c++;
				if (f == 0) begin
					f = n;
					i = gain_init_o;
				end
			end
			@(posedge mclk_i);
			#1;
		end
	endtask
	// ------------------------------------------------
	// clock, watchdog and sequence
	// ------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	initial begin
		#100000;
		bad_count++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, channel_sync_i, reg_addr_i, reg_wdata_i, external_sync_input_i} = '0;
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, q);
			chk(q, rows[i].e);
		end
		$display("test registers done");
		do_reset();
		foreach (ra[i]) begin
			rd(ra[i], q);
			chk(q, re[i]);
		end
		chk(20'({gain_loop_enable_o, gain_level_mode_o, in_ready_o, gain_sync_o}), 20'ha);
		chk(20'(out_sample_o), 20'h0);
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			wr(7'h09, 20'({c[2:0], c[1], 3'h0, c[0]}));
			xfer(16'hffff, q16);
			chk(20'(q16), 20'(msk[c]));
			chk(20'({gain_level_mode_o, gain_loop_enable_o}), 20'({c[1], ~c[0]}));
		end
		$display("test truncate done");
		for (int f = 0; f < 2; f++) begin
			prep();
			for (int c = 0; c < 4; c++) begin
				wr(f ? 7'h06 : 7'h00, 20'({c[1:0], 8'h00}));
				xfer(16'h4000, q16);
				chk(20'(q16), 20'(16'h0400 << c));
			end
			prep();
			wr(f ? 7'h06 : 7'h00, 20'h332);
			ptr_u.got_q.delete();
			for (int i = 1; i <= 8; i++) ptr_u.send(16'(i * 256), i % 2);
			collect(2);
			chk(20'(ptr_u.got_q.size()), 20'h2);
			chk(20'(ptr_u.got_q[0]), 20'h180);
			chk(20'(ptr_u.got_q[1]), 20'h380);
			for (int s = 0; s < 2; s++) begin
				prep();
				wr(f ? 7'h08 : 7'h02, 20'h2);
				wr(f ? 7'h06 : 7'h00, 20'({s[0], 10'h300}));
				ptr_u.got_q.delete();
				ptr_u.send(16'h4000, 0);
				ptr_u.send(16'h0000, 1);
				ptr_u.send(16'h0000, 0);
				collect(3);
				chk(20'(ptr_u.got_q[0]), 20'h2000);
				chk(20'(ptr_u.got_q[2]), s ? 20'h2000 : 20'h0);
			end
		end
		$display("test filters done");
		prep();
		wr(7'h03, 20'h2);
		wr(7'h04, 20'h3);
		wr(7'h05, 20'h0aaa);
		wr(7'h05, 20'h0bbb);
		wr(7'h05, 20'h0ccc);
		rd(7'h05, q);
		chk(q, 20'h0bbb);
		wr(7'h01, 20'h3);
		wr(7'h00, 20'h300);
		xfer(16'h4000, q16);
		chk(20'(q16), 20'h1776);
		$display("test pointer done");
		do_reset();
		for (int k = 0; k < 6; k++) begin
			g = k < 4 ? 11'({1'b0, k[1:0], 5'h0, k[0], 2'h0}) : 11'({1'b1, 7'h0, k[0], 2'h0});
			wr(7'h09, 20'(g));
			wr(7'h0a, 20'(k + 1));
			pulse(k < 4 ? ~(4'h1 << k) : 4'hf, 1'b0);
			watch(first, cnt, ini);
			chk(20'(cnt), 20'h0);
			if (k == 5) wr(7'h09, 20'(g | 11'h008));
			else pulse(k < 4 ? 4'h1 << k : 4'h0, k == 4);
			watch(first, cnt, ini);
			chk(20'(first), 20'(k + 1));
			chk(20'(cnt), 20'h1);
			chk(20'(ini), 20'(k % 2));
		end
		wr(7'h0a, 20'h0);
		wr(7'h09, 20'h008);
		watch(first, cnt, ini);
		chk(20'(cnt), 20'h0);
		for (int fo = 0; fo < 2; fo++) begin
			do_reset();
			wr(7'h09, 20'(fo * 2));
			pulse(4'h1, 1'b0);
			watch(first, cnt, ini);
			chk(20'(cnt), 20'h1);
			pulse(4'h1, 1'b0);
			watch(first, cnt, ini);
			chk(20'(cnt), 20'(1 - fo));
		end
		$display("test sync done");
		final_report();
	end
endmodule
